// ==== verilog/rpctl_defines.svh ====
`ifndef RPCTL_DEFINES_SVH
`define RPCTL_DEFINES_SVH

// Configuration offsets (byte addresses)
`define RPCTL_OFS_CONTROL      8'hbc
`define RPCTL_OFS_STATUS       8'hc0

// Control field positions
`define RPCTL_CTL_CE_BIT       0
`define RPCTL_CTL_NFE_BIT      1
`define RPCTL_CTL_FE_BIT       2
`define RPCTL_CTL_PME_EN_BIT   3
`define RPCTL_CTL_RESET        16'h0000

// Status field positions
`define RPCTL_STS_RID_MSB      15
`define RPCTL_STS_FLAG_BIT     16
`define RPCTL_STS_PEND_BIT     17
`define RPCTL_STS_RESET        32'h00000000

// Default depth of the pending PME queue
`define RPCTL_PME_DEPTH        4

`endif

// ==== verilog/rpctl_pkg.sv ====
package rpctl_pkg;
  typedef logic [15:0] rpctl_rid_t;
  typedef enum logic [1:0] {
    RPCTL_SEV_CORR,
    RPCTL_SEV_NONFATAL,
    RPCTL_SEV_FATAL,
    RPCTL_SEV_NONE
  } rpctl_sev_t;
endpackage

// ==== verilog/rpctl_pme_if.sv ====
`timescale 1ns/1ps
// Carries the pending-PME queue traffic between the control logic and the queue
interface rpctl_pme_if;
  import rpctl_pkg::*;
  logic       push;
  rpctl_rid_t push_rid;
  logic       pop;
  rpctl_rid_t head_rid;
  logic       not_empty;
  logic       full;
  modport ctl (output push, output push_rid, output pop,
               input head_rid, input not_empty, input full);
  modport que (input push, input push_rid, input pop,
               output head_rid, output not_empty, output full);
endinterface

// ==== verilog/rpctl_pme_queue.sv ====
`timescale 1ns/1ps
`include "rpctl_defines.svh"
// Holds Pme_status_flag that arrive while the status flag is still set
module rpctl_pme_queue
  import rpctl_pkg::*;
#(
  parameter int DEPTH = `RPCTL_PME_DEPTH
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  rpctl_pme_if.que  q
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 1) begin : g_depth_chk
    $error("DEPTH must be at least 1");
  end

  rpctl_rid_t        mem [DEPTH];
  logic [AW-1:0]     rd_ptr;
  logic [AW-1:0]     wr_ptr;
  logic [AW:0]       count;
  logic [AW-1:0]     next_rd_ptr;
  logic [AW-1:0]     next_wr_ptr;
  logic [AW:0]       next_count;
  logic              do_push;
  logic              do_pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_comb begin
    do_pop      = q.pop && (count != '0);
    // A full queue drops the newest PME; the link can only hold so many
    do_push     = q.push && (count != (AW+1)'(DEPTH));
    next_rd_ptr = do_pop ? inc(rd_ptr) : rd_ptr;
    next_wr_ptr = do_push ? inc(wr_ptr) : wr_ptr;
    next_count  = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= q.push_rid;
    end
  end

  assign q.head_rid  = mem[rd_ptr];
  assign q.not_empty = (count != '0);
  assign q.full      = (count == (AW+1)'(DEPTH));
endmodule

// ==== verilog/rpctl_root_port.sv ====
// Overview of operation
// - With the PME interrupt enable clear, no interrupt results from a received PME.
// - With the PME interrupt enable set, a PME that sets the status flag raises the interrupt.
// - Setting the enable from 0 to 1 while the status flag is set also raises the interrupt.
// - Fatal errors from the port or its hierarchy raise a system error only when enabled.
// - Non-fatal errors from the port or its hierarchy raise a system error only when enabled.
// - Correctable errors from the port or its hierarchy raise a system error only when enabled.
// - The three severity enables alone decide system errors; there is no command-register enable.
// - A PME arriving while the status flag is set sets the pending flag and is queued, or is dropped if the queue is full.
// - Clearing the status flag with a PME queued re-sets the flag and loads the queued ID.
// - The pending flag clears itself when the queue is empty and is read-only.
// - A PME arriving with the status flag clear sets the flag and records the requestor ID.
// - Writing 1 clears the status flag, writing 0 leaves it, and later Pme_status_flag wait meanwhile.
// - The requestor ID of the PME that set the status flag is shown in a 16-bit read-only field.
`timescale 1ns/1ps
`include "rpctl_defines.svh"
module rpctl_root_port
  import rpctl_pkg::*;
#(
  parameter int PME_DEPTH = `RPCTL_PME_DEPTH
) (
  // Clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_B,
  // Configuration access
  input  wire logic        I_CFG_WR,
  input  wire logic        I_CFG_RD,
  input  wire logic [7:0]  I_CFG_ADDR,
  input  wire logic [3:0]  I_CFG_BE,
  input  wire logic [31:0] I_CFG_WDATA,
  output logic      [31:0] O_CFG_RDATA,
  // PME messages from the hierarchy
  input  wire logic        I_PME_VALID,
  input  wire logic [15:0] I_PME_RID,
  // Error reports, one-cycle pulses, from the port or the hierarchy
  input  wire logic        I_ERR_FATAL,
  input  wire logic        I_ERR_NONFATAL,
  input  wire logic        I_ERR_CORR,
  // Event outputs
  output logic             O_PME_INT,
  output logic             O_INTERNAL_SYSTEM_ERROR
);
  // The queue needs at least one slot to hold a waiting PME
  if (PME_DEPTH < 1) begin : g_depth_chk
    $error("PME_DEPTH must be at least 1");
  end

  rpctl_pme_if pq();

  rpctl_pme_queue #(
    .DEPTH (PME_DEPTH)
  ) u_queue (
    .i_clk   (I_CORE_CLK),
    .i_rst_b (I_RST_B),
    .q       (pq.que)
  );

  // Control register fields
  logic        pme_interrupt_enable;
  logic        fatal_error_syserr_enable;
  logic        nonfatal_error_syserr_enable;
  logic        correctable_error_syserr_enable;
  logic        next_pme_interrupt_enable;
  logic        next_fatal_error_syserr_enable;
  logic        next_nonfatal_error_syserr_enable;
  logic        next_correctable_error_syserr_enable;

  // Status register fields
  logic        pme_status_flag;
  rpctl_rid_t  pme_requestor_id;
  logic        next_pme_status_flag;
  rpctl_rid_t  next_pme_requestor_id;

  // Outputs
  logic [31:0] next_cfg_rdata;
  logic        next_pme_int;
  logic        next_syserr;

  logic        wr_ctl;
  logic        wr_sts;
  logic        clear_req;
  logic        flag_after_clear;
  logic        pme_pending_flag;
  logic [15:0] ctl_word;
  logic [31:0] sts_word;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]);
  endfunction

  // Control register writes
  always_comb begin
    wr_ctl = I_CFG_WR && hit(I_CFG_ADDR, `RPCTL_OFS_CONTROL) && I_CFG_BE[0];
    next_pme_interrupt_enable            = pme_interrupt_enable;
    next_fatal_error_syserr_enable       = fatal_error_syserr_enable;
    next_nonfatal_error_syserr_enable    = nonfatal_error_syserr_enable;
    next_correctable_error_syserr_enable = correctable_error_syserr_enable;
    if (wr_ctl) begin
      next_pme_interrupt_enable            = I_CFG_WDATA[`RPCTL_CTL_PME_EN_BIT];
      next_fatal_error_syserr_enable       = I_CFG_WDATA[`RPCTL_CTL_FE_BIT];
      next_nonfatal_error_syserr_enable    = I_CFG_WDATA[`RPCTL_CTL_NFE_BIT];
      next_correctable_error_syserr_enable = I_CFG_WDATA[`RPCTL_CTL_CE_BIT];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pme_interrupt_enable            <= 1'b0;
      fatal_error_syserr_enable       <= 1'b0;
      nonfatal_error_syserr_enable    <= 1'b0;
      correctable_error_syserr_enable <= 1'b0;
    end else begin
      pme_interrupt_enable            <= next_pme_interrupt_enable;
      fatal_error_syserr_enable       <= next_fatal_error_syserr_enable;
      nonfatal_error_syserr_enable    <= next_nonfatal_error_syserr_enable;
      correctable_error_syserr_enable <= next_correctable_error_syserr_enable;
    end
  end

  // PME status, requestor ID and the queue of waiting Pme_status_flag
  always_comb begin
    wr_sts    = I_CFG_WR && hit(I_CFG_ADDR, `RPCTL_OFS_STATUS) && I_CFG_BE[2];
    clear_req = wr_sts && I_CFG_WDATA[`RPCTL_STS_FLAG_BIT] && pme_status_flag;
    flag_after_clear      = pme_status_flag && !clear_req;
    next_pme_status_flag  = flag_after_clear;
    next_pme_requestor_id = pme_requestor_id;
    pq.pop                = 1'b0;
    pq.push               = 1'b0;
    pq.push_rid           = I_PME_RID;
    if (!flag_after_clear && pq.not_empty) begin
      // Oldest queued PME goes first; a new arrival this cycle queues behind it unless the queue was full
      next_pme_status_flag  = 1'b1;
      next_pme_requestor_id = pq.head_rid;
      pq.pop                = 1'b1;
      pq.push               = I_PME_VALID;
    end else if (!flag_after_clear && I_PME_VALID) begin
      next_pme_status_flag  = 1'b1;
      next_pme_requestor_id = I_PME_RID;
    end else if (I_PME_VALID) begin
      // Status still set: hold the new PME rather than overwrite the ID
      pq.push = 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pme_status_flag  <= 1'b0;
      pme_requestor_id <= 16'h0000;
    end else begin
      pme_status_flag  <= next_pme_status_flag;
      pme_requestor_id <= next_pme_requestor_id;
    end
  end

  // Pending is derived from queue occupancy, so it drops by itself
  assign pme_pending_flag = pq.not_empty;

  // Read data, interrupt and system error
  always_comb begin
    ctl_word = `RPCTL_CTL_RESET;
    ctl_word[`RPCTL_CTL_PME_EN_BIT] = pme_interrupt_enable;
    ctl_word[`RPCTL_CTL_FE_BIT]    = fatal_error_syserr_enable;
    ctl_word[`RPCTL_CTL_NFE_BIT]   = nonfatal_error_syserr_enable;
    ctl_word[`RPCTL_CTL_CE_BIT]    = correctable_error_syserr_enable;
    sts_word = `RPCTL_STS_RESET;
    sts_word[`RPCTL_STS_RID_MSB:0] = pme_requestor_id;
    sts_word[`RPCTL_STS_FLAG_BIT]  = pme_status_flag;
    sts_word[`RPCTL_STS_PEND_BIT]  = pme_pending_flag;
    next_cfg_rdata = O_CFG_RDATA;
    if (I_CFG_RD) begin
      if (hit(I_CFG_ADDR, `RPCTL_OFS_CONTROL)) begin
        next_cfg_rdata = {16'h0000, ctl_word};
      end else if (hit(I_CFG_ADDR, `RPCTL_OFS_STATUS)) begin
        next_cfg_rdata = sts_word;
      end else begin
        next_cfg_rdata = 32'h00000000;
      end
    end
    // Level request: covers a new status with enable set and enable rising
    // over an already set status, and drops when either goes away
    next_pme_int = next_pme_interrupt_enable && next_pme_status_flag;
    // Severity enables alone gate errors; no command-register enable exists here
    next_syserr = (I_ERR_FATAL && fatal_error_syserr_enable)
               || (I_ERR_NONFATAL && nonfatal_error_syserr_enable)
               || (I_ERR_CORR && correctable_error_syserr_enable);
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_CFG_RDATA             <= 32'h00000000;
      O_PME_INT               <= 1'b0;
      O_INTERNAL_SYSTEM_ERROR <= 1'b0;
    end else begin
      O_CFG_RDATA             <= next_cfg_rdata;
      O_PME_INT               <= next_pme_int;
      O_INTERNAL_SYSTEM_ERROR <= next_syserr;
    end
  end
endmodule

// ==== test/rpctl_root_port_sva.sv ====
`timescale 1ns/1ps
module rpctl_root_port_chk
  import rpctl_pkg::*;
#(
  parameter int PME_DEPTH = 4
) (
  // Clock, reset and config access
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST_B,
  input wire logic        I_CFG_WR,
  input wire logic        I_CFG_RD,
  input wire logic [7:0]  I_CFG_ADDR,
  input wire logic [3:0]  I_CFG_BE,
  input wire logic [31:0] I_CFG_WDATA,
  input wire logic [31:0] O_CFG_RDATA,
  // Messages and events
  input wire logic        I_PME_VALID,
  input wire logic [15:0] I_PME_RID,
  input wire logic        I_ERR_FATAL,
  input wire logic        I_ERR_NONFATAL,
  input wire logic        I_ERR_CORR,
  input wire logic        O_PME_INT,
  input wire logic        O_INTERNAL_SYSTEM_ERROR
);
  logic [3:0] en;
  logic       sts_rd;
  assign sts_rd = I_CFG_RD && I_CFG_ADDR[7:2] == 6'h30;
  // Shadow of the enables, so the checks need no view inside
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      en <= 4'h0;
    end else if (I_CFG_WR && I_CFG_ADDR[7:2] == 6'h2f && I_CFG_BE[0]) begin
      en <= I_CFG_WDATA[3:0];
    end
  end
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  fatal_syserr_a: assert property (I_ERR_FATAL && en[2] |=> O_INTERNAL_SYSTEM_ERROR)
    else $error("fatal report lost");
  nonfatal_syserr_a: assert property (I_ERR_NONFATAL && en[1] |=> O_INTERNAL_SYSTEM_ERROR)
    else $error("nonfatal report lost");
  corr_syserr_a: assert property (I_ERR_CORR && en[0] |=> O_INTERNAL_SYSTEM_ERROR)
    else $error("correctable report lost");
  quiet_syserr_a: assert property (!(I_ERR_FATAL && en[2] || I_ERR_NONFATAL && en[1]
    || I_ERR_CORR && en[0]) |=> !O_INTERNAL_SYSTEM_ERROR) else $error("spurious system error");
  pme_masked_a: assert property (!en[3] |-> !O_PME_INT)
    else $error("interrupt while disabled");
  pme_raise_a: assert property (I_PME_VALID && en[3] && !I_CFG_WR |=> O_PME_INT)
    else $error("no interrupt after message");
  int_hold_a: assert property ($fell(O_PME_INT) |-> $past(I_CFG_WR))
    else $error("interrupt dropped without write");
  pend_flag_a: assert property (sts_rd |=> O_CFG_RDATA[31:18] == 14'h0
    && (!O_CFG_RDATA[17] || O_CFG_RDATA[16])) else $error("pending without status");
  cover property (I_PME_VALID && O_PME_INT);
  cover property (sts_rd && O_PME_INT);
  cover property (I_ERR_FATAL && en[2]);
endmodule
bind rpctl_root_port rpctl_root_port_chk #(.PME_DEPTH(PME_DEPTH)) chk_u (.I_CORE_CLK, .I_RST_B,
  .I_CFG_WR, .I_CFG_RD, .I_CFG_ADDR, .I_CFG_BE, .I_CFG_WDATA, .O_CFG_RDATA, .I_PME_VALID,
  .I_PME_RID, .I_ERR_FATAL, .I_ERR_NONFATAL, .I_ERR_CORR, .O_PME_INT, .O_INTERNAL_SYSTEM_ERROR);

// ==== test/rpctl_ep_model.sv ====
`timescale 1ns/1ps
// Endpoints below the port: one PME or error report per call
module rpctl_ep_model
  import rpctl_pkg::*;
(
  input  wire logic  i_clk,
  output logic       o_pme_valid,
  output rpctl_rid_t o_pme_rid,
  output logic [2:0] o_err
);
  initial begin
    o_pme_valid = 1'b0;
    o_pme_rid   = 16'h0;
    o_err       = 3'h0;
  end
  task automatic send_pme(input rpctl_rid_t rid);
    @(negedge i_clk);
    o_pme_valid = 1'b1;
    o_pme_rid   = rid;
    @(negedge i_clk);
    o_pme_valid = 1'b0;
    // ID means nothing without valid, so it must not linger
    o_pme_rid   = ~rid;
  endtask
  task automatic pulse_err(input logic [2:0] sev);
    @(negedge i_clk);
    o_err = sev;
    @(negedge i_clk);
    o_err = 3'h0;
  endtask
endmodule

// ==== test/root_port_pme_error_signaling_tb.sv ====
`timescale 1ns/1ps
module root_port_pme_error_signaling_tb;
  import rpctl_pkg::*;
  logic        clk, rst_b, wr, rd, pme_v, pme_int, ise, rd_seen;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata;
  logic [2:0]  err;
  rpctl_rid_t  pme_rid;
  rpctl_rid_t  ids [4];
  logic [32:0] exp_q [$];
  int          err_total, tests_run, seed;
  always #2.5 clk = ~clk;
  // Depth 2 so the fourth PME overflows
  rpctl_root_port #(.PME_DEPTH(2)) dut_u (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_CFG_WR(wr),
    .I_CFG_RD(rd), .I_CFG_ADDR(addr), .I_CFG_BE(be), .I_CFG_WDATA(wdata), .O_CFG_RDATA(rdata),
    .I_PME_VALID(pme_v), .I_PME_RID(pme_rid), .I_ERR_FATAL(err[2]), .I_ERR_NONFATAL(err[1]),
    .I_ERR_CORR(err[0]), .O_PME_INT(pme_int), .O_INTERNAL_SYSTEM_ERROR(ise));
  rpctl_ep_model ep_u (.i_clk(clk), .o_pme_valid(pme_v), .o_pme_rid(pme_rid), .o_err(err));
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    {wr, addr, be, wdata} = {1'b1, a, b, d};
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic cfg_rd(input logic [7:0] a, input logic [32:0] e);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    exp_q.push_back(e);
    @(negedge clk);
    rd = 1'b0;
  endtask
  // Scoreboard: read data lands one edge after the read
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) check({pme_int, rdata}, exp_q.pop_front());
  end
  task automatic sev_case(input int s, input logic on);
    // Off case enables the other severities, so no cross-talk hides
    cfg_wr(8'hbc, 4'h1, on ? 32'h1 << s : 32'h7 ^ (32'h1 << s));
    ep_u.pulse_err(3'(1 << s));
    check({32'h0, ise}, {32'h0, on});
  endtask
  initial begin
    {clk, rst_b, wr, rd, addr, be, wdata} = '0;
    {err_total, tests_run, seed} = {32'd0, 32'd0, 32'd3503};
    repeat (6) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    cfg_rd(8'hbc, 33'h0);
    cfg_rd(8'hc0, 33'h0);
    cfg_wr(8'hbc, 4'he, $random(seed));
    cfg_rd(8'hbc, 33'h0);
    cfg_rd(8'h10, 33'h0);
    for (int s = 0; s < 3; s++) for (int on = 0; on < 2; on++) sev_case(s, 1'(on));
    cfg_wr(8'hbc, 4'h1, 32'h0);
    for (int i = 0; i < 4; i++) ids[i] = 16'($random(seed));
    ep_u.send_pme(ids[0]);
    cfg_rd(8'hc0, {1'b0, 32'h1_0000 | ids[0]});
    cfg_wr(8'hbc, 4'h1, 32'h8);
    cfg_rd(8'hbc, {1'b1, 32'h8});
    for (int i = 1; i < 4; i++) ep_u.send_pme(ids[i]);
    cfg_rd(8'hc0, {1'b1, 32'h3_0000 | ids[0]});
    cfg_wr(8'hc0, 4'hb, 32'hffff_ffff);
    cfg_wr(8'hc0, 4'h4, 32'h0);
    cfg_rd(8'hc0, {1'b1, 32'h3_0000 | ids[0]});
    for (int k = 1; k < 3; k++) begin
      cfg_wr(8'hc0, 4'hf, 32'hffff_ffff);
      cfg_rd(8'hc0, {1'b1, (k == 1 ? 32'h3_0000 : 32'h1_0000) | ids[k]});
    end
    cfg_wr(8'hc0, 4'h4, 32'h1_0000);
    cfg_rd(8'hc0, {1'b0, 32'h0 | ids[2]});
    ep_u.send_pme(ids[3]);
    cfg_rd(8'hc0, {1'b1, 32'h1_0000 | ids[3]});
    @(negedge clk) rst_b = 1'b0;
    @(negedge clk) rst_b = 1'b1;
    cfg_rd(8'hc0, 33'h0);
    // Let the scoreboard take the last read before the verdict
    repeat (2) @(negedge clk);
    check(33'(exp_q.size()), 33'h0);
    close_out();
  end
  initial begin
    #20000;
    err_total++;
    close_out();
  end
endmodule
